// ===== rtl/lpcfg_gen.sv
// Overview of operation
// - Port mode 3/0/1/2 gives 8 bi, 4/2/1 duplex ports, 1024/2048/4096/8192.
// - Reference clock is 4, 2, 1, 0.5 times the data rate per mode.
// - Trunk strobes always come from trunk clock and trunk frame pulse.
// - Source 0: reference from trunk clock; frame from trunk pulse; drive pins.
// - Source 1: reference from line clock input; frame from line sync input.
// - Prescaler code 00 divides by 2, 01 by 1.5, 10 by 1.
// - Rate bit 0: bit clock output equals the data rate.
// - Rate bit 1: bit clock output doubles, only in modes 0 and 3.
// - Rate bit acts only with the internal source; frame form applies with either source.
// - Frame position against sync output ignores slot and shift settings.
// - Frame form field selects forms 0 to 4, 6 and 7; 5 reserved.
// - Form 0: low one-bit pulse at bit 251; send falling, sample rising, or on the second fall with the doubled clock.
// - Form 1 is form 0 delayed by half a reference clock period.
// - Form 2 is form 3 advanced by half a reference clock period.
// - Form 6: rising edge at first bit, high for 32 bits.
// - Form 4: like form 6 but starting at timeslot 2.
// - Form 7: form 3 shape for one frame after timer expiry, else form 6.
`timescale 1ns/100ps
module lpcfg_gen import lpcfg_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire lpcfg_bus_t bus_i,
	output logic [7:0] rdata_o,
	input wire lpcfg_pins_t pins_i,
	input wire logic mf_expire_i,
	output logic line_bit_clock_o,
	output logic line_bit_clock_oe_o,
	output logic line_frame_sync_o,
	output logic line_frame_sync_oe_o,
	output logic line_reference_clock_o,
	output logic tx_stb_o,
	output logic rx_stb_o,
	output logic frame_stb_o,
	output logic [9:0] bit_index_o,
	output logic trunk_bit_stb_o,
	output logic trunk_frame_stb_o,
	output logic [3:0] port_count_o,
	output logic [13:0] max_rate_o
);
	typedef struct packed {
		logic [7:0] mode_one;
		logic [7:0] mode_two;
		logic [7:0] bit_count_lo;
		logic [7:0] rdata;
		lpcfg_pins_t prev;
		logic [6:0] acc;
		logic [6:0] racc;
		logic [1:0] ph;
		logic [9:0] bit_cnt;
		logic bclk;
		logic ref_clk;
		logic fsync;
		logic oe;
		logic armed;
		logic [2:0] dly;
		logic mf_pending;
		logic mf_frame;
		logic tx_stb;
		logic rx_stb;
		logic frame_stb;
		logic trunk_bit_stb;
		logic trunk_frame_stb;
		logic [3:0] port_cnt;
		logic [13:0] max_rate;
	} lpcfg_state_t;

	lpcfg_state_t st;
	lpcfg_state_t next_st;
	lpcfg_pins_t sp;

	logic src_sel;
	lpcfg_port_mode_t pmode;
	lpcfg_presc_t pre;
	lpcfg_form_t form;
	logic rate2x;
	logic [9:0] nbits;
	logic src_edge;
	logic fs_rise;
	logic [6:0] thr;
	logic [6:0] rthr;
	logic [6:0] acc_sum;
	logic [6:0] racc_sum;
	logic half_tick;
	logic ref_half;
	logic [1:0] ph_last;
	logic [1:0] ph_mid;
	logic [1:0] ph_next;
	logic wrap;
	logic frame_evt;
	logic shape;
	logic [2:0] dly_need;

	// Source clock periods per reference period, in half-periods
	function automatic logic [2:0] presc_units(input lpcfg_presc_t p);
		case (p)
			PS_DIV2: presc_units = 3'h4;
			PS_DIV1P5: presc_units = 3'h3;
			default: presc_units = 3'h2;
		endcase
	endfunction

	// Reference half-periods per bit
	function automatic logic [3:0] bit_units(input lpcfg_port_mode_t m);
		case (m)
			PM_BIDIR8: bit_units = 4'h8;
			PM_DUPLEX4: bit_units = 4'h4;
			PM_DUPLEX2: bit_units = 4'h2;
			default: bit_units = 4'h1;
		endcase
	endfunction

	// Logical port count per mode
	function automatic logic [3:0] port_count(input lpcfg_port_mode_t m);
		case (m)
			PM_BIDIR8: port_count = 4'h8;
			PM_DUPLEX4: port_count = 4'h4;
			PM_DUPLEX2: port_count = 4'h2;
			default: port_count = 4'h1;
		endcase
	endfunction

	// Highest line data rate per mode
	function automatic logic [13:0] max_rate(input lpcfg_port_mode_t m);
		case (m)
			PM_BIDIR8: max_rate = RATE_MAX_BIDIR8;
			PM_DUPLEX4: max_rate = RATE_MAX_DUPLEX4;
			PM_DUPLEX2: max_rate = RATE_MAX_DUPLEX2;
			default: max_rate = RATE_MAX_DUPLEX1;
		endcase
	endfunction

	// Frame sync level for a bit position; counter is never shifted
	function automatic logic frame_shape(input lpcfg_form_t f,
			input logic [9:0] b, input logic [9:0] n, input logic mf);
		logic wide;
		wide = b < WIDE_PULSE_BITS;
		case (f)
			FF_BURST, FF_LATE: frame_shape = b != MARK_BIT_BURST;
			FF_EARLY: frame_shape = b == n;
			FF_SINGLE: frame_shape = b == 10'h000;
			FF_SHIFTED: frame_shape = (b >= SHIFTED_START_BIT) &&
				(b < SHIFTED_START_BIT + WIDE_PULSE_BITS);
			FF_MULTI: frame_shape = mf ? (b == 10'h000) : wide;
			default: frame_shape = wide;
		endcase
	endfunction

	lpcfg_sync lpcfg_sync_inst (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.pins_i(pins_i),
		.pins_o(sp)
	);

	// Configuration fields
	assign src_sel = st.mode_one[M1_SRC_POS];
	assign pmode = lpcfg_port_mode_t'(st.mode_one[M1_PMODE_POS +: 2]);
	assign pre = lpcfg_presc_t'(st.mode_one[M1_PRE_POS +: 2]);
	assign form = lpcfg_form_t'(st.mode_two[M2_FORM_POS +: 3]);
	assign rate2x = st.mode_two[M2_RATE_POS] && !src_sel &&
		(pmode == PM_DUPLEX4 || pmode == PM_BIDIR8);
	assign nbits = {st.mode_two[M2_CNT_POS +: 2], st.bit_count_lo};

	// Selected clock and frame source
	assign src_edge = src_sel ? (sp.line_clk ^ st.prev.line_clk)
		: (sp.trunk_clk ^ st.prev.trunk_clk);
	assign fs_rise = src_sel ? (sp.line_fs & ~st.prev.line_fs)
		: (sp.trunk_fp & ~st.prev.trunk_fp);

	// Thresholds in units: bit clock half-period and reference half
	assign thr = ({4'h0, presc_units(pre)} * {3'h0, bit_units(pmode)})
		>> rate2x;
	assign rthr = {3'h0, presc_units(pre), 1'b0};
	assign acc_sum = st.acc + (src_edge ? UNITS_PER_EDGE : 7'h00);
	assign racc_sum = st.racc + (src_edge ? UNITS_PER_EDGE : 7'h00);
	assign half_tick = acc_sum >= thr;
	assign ref_half = racc_sum >= rthr;

	// Phase within a bit: two halves, or four with the doubled clock
	assign ph_last = rate2x ? 2'h3 : 2'h1;
	assign ph_mid = rate2x ? 2'h2 : 2'h1;
	// A phase left over from the doubled clock folds back at once
	assign ph_next = (st.ph >= ph_last) ? 2'h0 : st.ph + 2'h1;
	assign wrap = half_tick && ph_next == 2'h0 && st.bit_cnt == nbits;
	assign frame_evt = fs_rise | wrap;

	// Frame sync shape and its half-reference delay
	assign shape = frame_shape(form, st.bit_cnt, nbits, st.mf_frame);
	assign dly_need = (form == FF_LATE) ? 3'h1 :
		(form == FF_EARLY) ? 3'(bit_units(pmode) - 4'h1) : 3'h0;

	// Next state
	always_comb begin
		next_st = st;
		next_st.rdata = 8'h00;
		next_st.tx_stb = 1'b0;
		next_st.rx_stb = 1'b0;
		next_st.frame_stb = 1'b0;
		next_st.prev = sp;
		if (bus_i.wr) begin
			if (bus_i.addr == OFF_MODE_ONE) begin
				next_st.mode_one = bus_i.wdata;
			end else if (bus_i.addr == OFF_MODE_TWO) begin
				next_st.mode_two = bus_i.wdata;
			end else if (bus_i.addr == OFF_BIT_COUNT) begin
				next_st.bit_count_lo = bus_i.wdata;
			end
		end
		if (bus_i.rd) begin
			if (bus_i.addr == OFF_MODE_ONE) begin
				next_st.rdata = st.mode_one;
			end else if (bus_i.addr == OFF_MODE_TWO) begin
				next_st.rdata = st.mode_two;
			end else if (bus_i.addr == OFF_BIT_COUNT) begin
				next_st.rdata = st.bit_count_lo;
			end else if (bus_i.addr == OFF_STATUS) begin
				next_st.rdata = {st.mf_pending, st.mf_frame, st.fsync,
					st.bclk, st.ref_clk, st.armed, st.bit_cnt[9:8]};
			end else if (bus_i.addr == OFF_POSITION) begin
				next_st.rdata = st.bit_cnt[7:0];
			end
		end
		next_st.port_cnt = port_count(pmode);
		next_st.max_rate = max_rate(pmode);
		next_st.oe = !src_sel;
		// Trunk side always follows its own clock and pulse
		next_st.trunk_bit_stb = sp.trunk_clk & ~st.prev.trunk_clk;
		next_st.trunk_frame_stb = sp.trunk_fp & ~st.prev.trunk_fp;
		// Prescaler and reference clock
		next_st.acc = half_tick ? acc_sum - thr : acc_sum;
		next_st.racc = ref_half ? racc_sum - rthr : racc_sum;
		if (ref_half) begin
			next_st.ref_clk = ~st.ref_clk;
		end
		// Bit clock: falling edge starts a bit; the rise samples it, or the second fall with the doubled clock
		if (half_tick) begin
			next_st.ph = ph_next;
			next_st.bclk = ph_next[0];
			if (ph_next == 2'h0) begin
				next_st.tx_stb = 1'b1;
				next_st.bit_cnt = wrap ? 10'h000 : st.bit_cnt + 10'h001;
			end
			if (ph_next == ph_mid) begin
				next_st.rx_stb = 1'b1;
			end
		end
		// Frame alignment to the selected frame pulse
		if (fs_rise) begin
			next_st.bit_cnt = 10'h000;
			next_st.ph = 2'h0;
			next_st.bclk = 1'b0;
			next_st.acc = 7'h00;
		end
		if (frame_evt) begin
			next_st.frame_stb = 1'b1;
			next_st.mf_frame = st.mf_pending;
			next_st.mf_pending = 1'b0;
		end
		// Expiry arriving with the frame start is kept
		if (mf_expire_i) begin
			next_st.mf_pending = 1'b1;
		end
		// Frame sync output, optionally delayed in reference halves
		if (!st.armed) begin
			if (shape != st.fsync) begin
				if (dly_need == 3'h0) begin
					next_st.fsync = shape;
				end else begin
					next_st.armed = 1'b1;
					next_st.dly = dly_need;
				end
			end
		end else if (ref_half) begin
			if (st.dly == 3'h1) begin
				next_st.fsync = shape;
				next_st.armed = 1'b0;
			end else begin
				next_st.dly = st.dly - 3'h1;
			end
		end
	end

	// State register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
			st.mode_one <= RST_MODE_ONE;
			st.mode_two <= RST_MODE_TWO;
			st.bit_count_lo <= RST_BIT_COUNT;
			st.port_cnt <= RST_PORT_CNT;
			st.max_rate <= RST_MAX_RATE;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign rdata_o = st.rdata;
	assign line_bit_clock_o = st.bclk;
	assign line_bit_clock_oe_o = st.oe;
	assign line_frame_sync_o = st.fsync;
	assign line_frame_sync_oe_o = st.oe;
	assign line_reference_clock_o = st.ref_clk;
	assign tx_stb_o = st.tx_stb;
	assign rx_stb_o = st.rx_stb;
	assign frame_stb_o = st.frame_stb;
	assign bit_index_o = st.bit_cnt;
	assign trunk_bit_stb_o = st.trunk_bit_stb;
	assign trunk_frame_stb_o = st.trunk_frame_stb;
	assign port_count_o = st.port_cnt;
	assign max_rate_o = st.max_rate;

	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Output enable lags reset release by one edge
	property p_drive_int;
		$past(rst_n_i) && !src_sel ##1 !src_sel |->
			line_bit_clock_oe_o && line_frame_sync_oe_o;
	endproperty
	a_drive_int: assert property (p_drive_int)
		else $error("pins not driven with internal source");

	property p_release_ext;
		src_sel ##1 src_sel |-> !line_bit_clock_oe_o && !line_frame_sync_oe_o;
	endproperty
	a_release_ext: assert property (p_release_ext)
		else $error("pins driven with external source");

	property p_trunk;
		sp.trunk_clk && !st.prev.trunk_clk |=> trunk_bit_stb_o;
	endproperty
	a_trunk: assert property (p_trunk)
		else $error("trunk clock edge lost");

	property p_frame_align;
		fs_rise |=> bit_index_o == 10'h000 && frame_stb_o;
	endproperty
	a_frame_align: assert property (p_frame_align)
		else $error("frame not aligned to frame pulse");

	property p_edges;
		tx_stb_o |-> !line_bit_clock_o;
	endproperty
	a_edges: assert property (p_edges)
		else $error("transmit strobe not on falling clock");

	property p_burst;
		(form == FF_BURST && !st.armed && st.bit_cnt == MARK_BIT_BURST)
			##1 (form == FF_BURST) |-> !line_frame_sync_o;
	endproperty
	a_burst: assert property (p_burst)
		else $error("burst mark pulse missing");

	property p_wide;
		(form == FF_WIDE && !st.armed) |=>
			line_frame_sync_o == ($past(st.bit_cnt) < WIDE_PULSE_BITS);
	endproperty
	a_wide: assert property (p_wide)
		else $error("wide frame pulse wrong");

	sequence s_late_arm;
		form == FF_LATE && !st.armed && shape != st.fsync;
	endsequence
	sequence s_late_wait;
		(line_frame_sync_o == $past(st.fsync)) [*1];
	endsequence
	property p_late;
		s_late_arm |=> s_late_wait ##[0:1000] st.fsync == shape;
	endproperty
	a_late: assert property (p_late)
		else $error("late frame pulse not applied");

	// Divide by one: each source edge is one reference half, no remainder
	sequence s_one_half;
		ref_half ##1 st.racc == 7'h00;
	endsequence
	property p_div1;
		pre == PS_DIV1 && src_edge && st.racc == 7'h00 |-> s_one_half;
	endproperty
	a_div1: assert property (p_div1)
		else $error("divide by one wrong");

	property p_rate_lim;
		(pmode == PM_DUPLEX2 || pmode == PM_DUPLEX1) && half_tick |=>
			st.ph <= 2'h1;
	endproperty
	a_rate_lim: assert property (p_rate_lim)
		else $error("doubled clock in wrong mode");

	property p_mf;
		frame_evt && st.mf_pending |=> st.mf_frame;
	endproperty
	a_mf: assert property (p_mf)
		else $error("multiframe shape not taken");

	property p_ports;
		pmode == PM_BIDIR8 ##1 pmode == PM_BIDIR8 |-> port_count_o == 4'h8;
	endproperty
	a_ports: assert property (p_ports)
		else $error("port count wrong");
endmodule

// ===== rtl/lpcfg_pkg.sv
package lpcfg_pkg;

	// Register bus geometry
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [2:0] OFF_MODE_ONE = 3'h0;
	localparam logic [2:0] OFF_MODE_TWO = 3'h1;
	localparam logic [2:0] OFF_BIT_COUNT = 3'h2;
	localparam logic [2:0] OFF_STATUS = 3'h3;
	localparam logic [2:0] OFF_POSITION = 3'h4;

	// Values after reset
	localparam logic [7:0] RST_MODE_ONE = 8'h00;
	localparam logic [7:0] RST_MODE_TWO = 8'h00;
	localparam logic [7:0] RST_BIT_COUNT = 8'hff;
	localparam logic [3:0] RST_PORT_CNT = 4'h4;
	localparam logic [13:0] RST_MAX_RATE = 14'h0800;

	// Field positions in line_mode_reg_one
	localparam int M1_SRC_POS = 7;
	localparam int M1_PRE_POS = 4;
	localparam int M1_PMODE_POS = 2;

	// Field positions in line_mode_reg_two
	localparam int M2_FORM_POS = 5;
	localparam int M2_RATE_POS = 4;
	localparam int M2_CNT_POS = 0;

	// Timing units: one source clock edge adds this many units
	localparam logic [6:0] UNITS_PER_EDGE = 7'h04;

	// Frame sync placement in bits
	localparam logic [9:0] MARK_BIT_BURST = 10'h0fb;
	localparam logic [9:0] WIDE_PULSE_BITS = 10'h020;
	localparam logic [9:0] SHIFTED_START_BIT = 10'h010;

	// Data rate limits in kbit/s
	localparam logic [13:0] RATE_MIN = 14'h0080;
	localparam logic [13:0] RATE_MAX_BIDIR8 = 14'h0400;
	localparam logic [13:0] RATE_MAX_DUPLEX4 = 14'h0800;
	localparam logic [13:0] RATE_MAX_DUPLEX2 = 14'h1000;
	localparam logic [13:0] RATE_MAX_DUPLEX1 = 14'h2000;

	typedef enum logic [1:0] {
		PM_DUPLEX4 = 2'h0,
		PM_DUPLEX2 = 2'h1,
		PM_DUPLEX1 = 2'h2,
		PM_BIDIR8 = 2'h3
	} lpcfg_port_mode_t;

	typedef enum logic [1:0] {
		PS_DIV2 = 2'h0,
		PS_DIV1P5 = 2'h1,
		PS_DIV1 = 2'h2,
		PS_BAD = 2'h3
	} lpcfg_presc_t;

	typedef enum logic [2:0] {
		FF_BURST = 3'h0,
		FF_LATE = 3'h1,
		FF_EARLY = 3'h2,
		FF_SINGLE = 3'h3,
		FF_SHIFTED = 3'h4,
		FF_RSVD = 3'h5,
		FF_WIDE = 3'h6,
		FF_MULTI = 3'h7
	} lpcfg_form_t;

	typedef struct packed {
		logic trunk_clk;
		logic trunk_fp;
		logic line_clk;
		logic line_fs;
	} lpcfg_pins_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} lpcfg_bus_t;

	typedef struct packed {
		lpcfg_pins_t s1;
		lpcfg_pins_t s2;
	} lpcfg_sync_t;

endpackage

// ===== rtl/lpcfg_sync.sv
`timescale 1ns/100ps
module lpcfg_sync import lpcfg_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire lpcfg_pins_t pins_i,
	output lpcfg_pins_t pins_o
);
	lpcfg_sync_t st;
	lpcfg_sync_t next_st;

	// Two flip-flop stages for every pin
	always_comb begin
		next_st.s1 = pins_i;
		next_st.s2 = st.s1;
	end

	// State register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pins_o = st.s2;
endmodule

// ===== tb/lpcfg_far_end.sv
`timescale 1ns/100ps
module lpcfg_far_end import lpcfg_pkg::*; #(
	parameter int TRUNK_HALF = 8,
	parameter int LINE_HALF = 12
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic line_run_i,
	input wire logic fp_req_i,
	input wire logic fs_req_i,
	output lpcfg_pins_t pins_o
);
	int tcnt;
	int lcnt;
	int fp_left;
	int fs_left;
	logic tclk;
	logic lclk;

	// Trunk clock runs free, line clock stands still unless traffic runs
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tcnt <= 0;
			lcnt <= 0;
			tclk <= 1'h0;
			lclk <= 1'h0;
		end else begin
			tcnt <= (tcnt == TRUNK_HALF - 1) ? 0 : tcnt + 1;
			if (tcnt == TRUNK_HALF - 1) tclk <= ~tclk;
			if (line_run_i) begin
				lcnt <= (lcnt == LINE_HALF - 1) ? 0 : lcnt + 1;
				if (lcnt == LINE_HALF - 1) lclk <= ~lclk;
			end
		end
	end

	// Frame pulses stay high two source periods, then fall low again
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fp_left <= 0;
			fs_left <= 0;
		end else begin
			fp_left <= fp_req_i ? 4 * TRUNK_HALF : (fp_left > 0 ? fp_left - 1 : 0);
			fs_left <= fs_req_i ? 4 * LINE_HALF : (fs_left > 0 ? fs_left - 1 : 0);
		end
	end

	assign pins_o = '{trunk_clk: tclk, trunk_fp: fp_left > 0,
		line_clk: lclk, line_fs: fs_left > 0};
endmodule

// ===== tb/test_line_port_clock_frame_gen.sv
`timescale 1ns/100ps
module test_line_port_clock_frame_gen import lpcfg_pkg::*; ;
	logic clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	lpcfg_bus_t bus;
	logic mf, run, fp_req, fs_req;
	logic [7:0] rdata;
	logic bclk, bclk_oe, fsync, fsync_oe, rclk, fstb, tstb;
	logic txs, rxs, tfs;
	logic [9:0] bidx;
	logic [3:0] pcnt;
	logic [13:0] mrate;
	lpcfg_pins_t far_pins, pins;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;

	always #2 clk_i = ~clk_i;

	// Line pins: the design wins while it drives, else the far end
	assign pins = '{trunk_clk: far_pins.trunk_clk,
		trunk_fp: far_pins.trunk_fp,
		line_clk: bclk_oe ? bclk : far_pins.line_clk,
		line_fs: fsync_oe ? fsync : far_pins.line_fs};

	lpcfg_gen lpcfg_gen_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.bus_i(bus), .rdata_o(rdata), .pins_i(pins), .mf_expire_i(mf),
		.line_bit_clock_o(bclk), .line_bit_clock_oe_o(bclk_oe),
		.line_frame_sync_o(fsync), .line_frame_sync_oe_o(fsync_oe),
		.line_reference_clock_o(rclk), .tx_stb_o(txs), .rx_stb_o(rxs),
		.frame_stb_o(fstb), .bit_index_o(bidx), .trunk_bit_stb_o(tstb),
		.trunk_frame_stb_o(tfs), .port_count_o(pcnt), .max_rate_o(mrate));

	lpcfg_far_end lpcfg_far_end_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.line_run_i(run), .fp_req_i(fp_req), .fs_req_i(fs_req),
		.pins_o(far_pins));

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Cut a hang short
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 90000) begin
			error_cnt++;
			$display("[ERR] %0t timeout", $time);
			tally_and_finish;
		end
	end

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Count or position, one step of slack for edge phase
	task automatic chk_cnt(input logic [15:0] got, input int exp);
		compares++;
		if ($isunknown(got) || int'(got) < exp - 1 || int'(got) > exp + 1) begin
			error_cnt++;
			$display("[ERR] %0t got %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
		@(posedge clk_i);
		bus.wr <= 1'h0;
	endtask

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
		@(posedge clk_i);
		bus.rd <= 1'h0;
		#1 chk_val(16'(rdata), 16'(exp));
	endtask

	task automatic cfg(input logic src, input logic [1:0] ps,
		input logic [1:0] pm, input logic [2:0] ff, input logic rt);
		wr(OFF_MODE_ONE, {src, 1'h0, ps, pm, 2'h0});
		wr(OFF_MODE_TWO, {ff, rt, 4'h0});
		wr(OFF_BIT_COUNT, 8'hff);
		repeat (64) @(posedge clk_i);
		#1;
	endtask

	// Rising edges and strobes over n system cycles
	task automatic meas(input int n, output int b, output int r, output int t,
		output int x, output int y);
		logic pb, pr;
		b = 0;
		r = 0;
		t = 0;
		x = 0;
		y = 0;
		pb = bclk;
		pr = rclk;
		repeat (n) begin
			@(posedge clk_i);
			#1;
			b += int'(bclk & ~pb);
			r += int'(rclk & ~pr);
			t += int'(tstb);
			x += int'(txs);
			y += int'(rxs);
			pb = bclk;
			pr = rclk;
		end
	endtask

	// Frame sync high count at bit clock rises, and index where it rose
	task automatic fs_high(input int nb, output int hi, output logic [9:0] ri);
		logic pb, pf;
		int n;
		hi = 0;
		n = 0;
		ri = 10'h3ff;
		pb = bclk;
		pf = fsync;
		while (n < nb) begin
			@(posedge clk_i);
			#1;
			if (bclk === 1'h1 && pb === 1'h0) begin
				n++;
				hi += int'(fsync);
				if (fsync === 1'h1 && pf === 1'h0) ri = bidx;
				pf = fsync;
			end
			pb = bclk;
		end
	endtask

	task automatic wait_fstb(input int lim);
		int w;
		w = 0;
		while (fstb !== 1'h1 && w < lim) begin
			@(posedge clk_i);
			#1;
			w++;
		end
		chk_val(16'(w < lim), 16'h0001);
	endtask

	task automatic wait_idx;
		int w;
		w = 0;
		while (bidx !== 10'h014 && w < 8000) begin
			@(posedge clk_i);
			#1;
			w++;
		end
	endtask

	task automatic t_reset;
		chk_val(16'(pcnt), 16'(RST_PORT_CNT));
		chk_val(16'(mrate), 16'(RST_MAX_RATE));
		chk_val(16'({bclk_oe, fsync_oe}), 16'h0003);
		rd_chk(OFF_MODE_ONE, RST_MODE_ONE);
		rd_chk(OFF_MODE_TWO, RST_MODE_TWO);
		rd_chk(OFF_BIT_COUNT, RST_BIT_COUNT);
		rd_chk(3'h5, 8'h00);
	endtask

	task automatic t_modes;
		logic [3:0] pc[4] = '{4'h4, 4'h2, 4'h1, 4'h8};
		logic [13:0] mr[4] = '{14'h0800, 14'h1000, 14'h2000, 14'h0400};
		for (int i = 0; i < 4; i++) begin
			cfg(1'h0, 2'h0, 2'(i), 3'h6, 1'h0);
			chk_val(16'(pcnt), 16'(pc[i]));
			chk_val(16'(mrate), 16'(mr[i]));
			rd_chk(OFF_MODE_ONE, {4'h0, 2'(i), 2'h0});
		end
	endtask

	// Window of 48 trunk periods; d2 is twice the divisor, r2 twice REFERENCE_CLOCK_LINE/DR
	task automatic t_rates;
		int pm[11] = '{0, 0, 0, 0, 3, 3, 3, 1, 2, 1, 1};
		int ps[11] = '{0, 1, 2, 0, 2, 2, 0, 0, 0, 2, 0};
		int rt[11] = '{0, 0, 0, 1, 0, 1, 0, 0, 0, 0, 1};
		int d2, r2, b, r, t, x, y, nb, dbl;
		for (int i = 0; i < 11; i++) begin
			d2 = (ps[i] == 0) ? 4 : (ps[i] == 1) ? 3 : 2;
			r2 = (pm[i] == 3) ? 8 : (pm[i] == 0) ? 4 : (pm[i] == 1) ? 2 : 1;
			nb = 192 / (d2 * r2);
			// Doubled bit clock only counts in port modes 0 and 3
			dbl = (pm[i] == 0 || pm[i] == 3) ? rt[i] : 0;
			cfg(1'h0, 2'(ps[i]), 2'(pm[i]), 3'h6, rt[i][0]);
			meas(768, b, r, t, x, y);
			chk_cnt(16'(b), nb * (dbl + 1));
			chk_cnt(16'(x), nb);
			chk_cnt(16'(y), nb);
			chk_cnt(16'(r), 96 / d2);
			chk_cnt(16'(t), 48);
		end
	endtask

	// Every form but the reserved code, over one 256 bit frame
	task automatic t_forms;
		int ff[7] = '{0, 1, 2, 3, 4, 6, 7};
		int eh[7] = '{255, 255, 1, 1, 32, 32, 32};
		int ei[7] = '{252, 252, -1, 0, 16, 0, 0};
		int hi;
		logic [9:0] ri;
		for (int i = 0; i < 7; i++) begin
			cfg(1'h0, 2'h2, 2'h1, 3'(ff[i]), 1'h0);
			chk_val(16'(fsync_oe), 16'h0001);
			fs_high(256, hi, ri);
			chk_cnt(16'(hi), eh[i]);
			if (ei[i] >= 0) chk_cnt(16'(ri), ei[i]);
		end
	endtask

	task automatic t_multi;
		int hi;
		logic [9:0] ri;
		wait_fstb(8000);
		@(posedge clk_i);
		mf <= 1'h1;
		@(posedge clk_i);
		mf <= 1'h0;
		#1 wait_fstb(8000);
		fs_high(256, hi, ri);
		chk_cnt(16'(hi), 1);
		fs_high(256, hi, ri);
		chk_cnt(16'(hi), 32);
	endtask

	// Trunk pulse mid-frame restarts the line frame at once
	task automatic t_trunk_sync;
		wait_idx;
		@(posedge clk_i);
		fp_req <= 1'h1;
		@(posedge clk_i);
		fp_req <= 1'h0;
		#1 wait_fstb(80);
		chk_val(16'(tfs), 16'h0001);
	endtask

	task automatic t_external;
		int b, r, t, x, y;
		run <= 1'h1;
		cfg(1'h1, 2'h2, 2'h1, 3'h0, 1'h0);
		chk_val(16'({bclk_oe, fsync_oe}), 16'h0000);
		meas(960, b, r, t, x, y);
		chk_cnt(16'(r), 40);
		chk_cnt(16'(b), 40);
		chk_cnt(16'(x), 40);
		chk_cnt(16'(t), 60);
		wait_idx;
		@(posedge clk_i);
		fs_req <= 1'h1;
		@(posedge clk_i);
		fs_req <= 1'h0;
		#1 wait_fstb(120);
		run <= 1'h0;
	endtask

	initial begin
		bus = '0;
		mf = 1'h0;
		run = 1'h0;
		fp_req = 1'h0;
		fs_req = 1'h0;
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'h1;
		@(posedge clk_i);
		#1;
		t_reset;
		t_modes;
		t_rates;
		t_forms;
		t_multi;
		t_trunk_sync;
		t_external;
		tally_and_finish;
	end
endmodule
